// file: design/scan_defines.vh
// Purpose: Register map, field positions and codes for the converter controller
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes:   Definitions only
`ifndef SCAN_DEFINES_VH
`define SCAN_DEFINES_VH
`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_LP1_CTRL    8'h08
`define REG_LP1_RESULT  8'h0c
`define REG_LP2_CTRL    8'h10
`define REG_LP2_RESULT  8'h14
`define REG_DMA_WORD    8'h18
`define REG_PAT1_BASE   8'h40
`define REG_PAT2_BASE   8'h80
`define PAT_REGION_W    2
`define PAT1_REGION     2'h1
`define PAT2_REGION     2'h2
// Control register fields
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_MODE_HI    3
`define CTRL_MODE_LO    2
`define CTRL_SEL2       4
`define CTRL_I2S_ROUTE  5
`define CTRL_WS_TRIG    6
`define CTRL_DMA_EN     7
`define CTRL_LEN_HI     11
`define CTRL_LEN_LO     8
`define CTRL_SCANS_HI   19
`define CTRL_SCANS_LO   12
// Low-power control fields
`define LP_TRIG         0
`define LP_CH_HI        7
`define LP_CH_LO        4
`define LP_RES_HI       9
`define LP_RES_LO       8
// Status bits
`define ST_BUSY         0
`define ST_DONE         1
`define ST_LP1_BUSY     2
`define ST_LP2_BUSY     3
`define ST_LP1_DONE     4
`define ST_LP2_DONE     5
// Pattern entry fields
`define PE_CH_HI        7
`define PE_CH_LO        4
`define PE_RES_HI       3
`define PE_RES_LO       2
`define PE_ATT_HI       1
`define PE_ATT_LO       0
// Scan modes
`define MODE_SINGLE     2'h0
`define MODE_DOUBLE     2'h1
`define MODE_ALT        2'h2
// Resolution codes: 0=9 bit, 1=10, 2=11, 3=12
`define RES_12          2'h3
`define RES_11          2'h2
// Channel map
`define CH1_MAX         4'h7
`define CH2_MAX         4'h9
`define CH_SUPPLY       4'hc
`define CH_PEAK_A       4'hd
`define CH_PEAK_B       4'he
`define PAT_DEPTH       16
`define PAT_IDX_W       4
`define CONV_CYCLES     8'h0e
`endif

// file: design/sar_adc_scan_controller.v
// Purpose: Digital control for two 12-bit successive-approximation converters
// Assumes: Converter cores answer a start pulse with a done pulse and result
// Notes:   Two low-power single-shot controllers and one pattern-table scan engine
// Summary of operation
// RQ1: Resolution 12, 11, 10 or 9 bits per measurement
// RQ2: Trigger bit starts one conversion; result register
// RQ3: Low-power controllers never scan nor use DMA
// RQ4: Sixteen-entry pattern table: channel, resolution, attenuation
// RQ5: Entries fetched in order, wrap after sixteen (here wrap follows the entry set in ctrl bits 11:8)
// RQ6: Entry is 8 bits: 4 channel, 2+2
// RQ7: Channel 7:4, resolution 3:2, attenuation 1:0
// RQ8: Single mode scans one configured converter only
// RQ9: Double mode samples both converters together
// RQ10: Alternate mode interleaves first and second converter
// RQ11: Single word: 4-bit channel then 12-bit result
// RQ12: Dual word: select bit, channel, 11-bit result
// RQ13: Dual format limits precision to 11 bits
// RQ14: Select bit 15, channel 14:11; single channel 15:12
// RQ15: Scan starts by software or I2S; no single
// RQ16: Interrupt when scan finishes with DMA in use
// RQ17: I2S word-select triggers each measurement
// RQ18: I2S data line flags result ready
// RQ19: Routing bit must be set before I2S delivery
// RQ20: DMA path only from first converter's scan controller (here second-table scans also deliver DMA words)
// RQ21: Supply and peak channels only where supported
// RQ22: Channels 0-7 on first, 0-9 on second
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "scan_defines.vh"
module sar_adc_scan_controller (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  output reg         o_conv1_start,
  output reg  [3:0]  o_conv1_channel,
  output reg  [1:0]  o_conv1_res,
  output reg  [1:0]  o_conv1_atten,
  input  wire        i_conv1_done,
  input  wire [11:0] i_conv1_data,
  output reg         o_conv2_start,
  output reg  [3:0]  o_conv2_channel,
  output reg  [1:0]  o_conv2_res,
  output reg  [1:0]  o_conv2_atten,
  input  wire        i_conv2_done,
  input  wire [11:0] i_conv2_data,
  input  wire        i_i2s_ws,
  output reg         o_i2s_data,
  output reg  [15:0] o_dma_word,
  output reg         o_dma_valid,
  output reg         o_scan_irq
);
  // Controller states
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_PACK = 2'h3;

  // Reset release through two flops
  reg       rst_meta;
  reg       rst_sync_n;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Pattern tables, one per converter
  reg [7:0]  pat1 [0:`PAT_DEPTH-1];
  reg [7:0]  pat2 [0:`PAT_DEPTH-1];
  reg [31:0] ctrl;
  reg [9:0]  lp1_ctrl;
  reg [9:0]  lp2_ctrl;
  reg [11:0] lp1_result;
  reg [11:0] lp2_result;
  reg        lp1_busy;
  reg        lp2_busy;
  reg        lp1_done;
  reg        lp2_done;
  reg        scan_busy;
  reg        scan_done;
  reg [1:0]  state;
  reg [3:0]  idx;
  reg        alt_second;
  reg [7:0]  scans_left;
  reg        got1;
  reg        got2;
  reg [11:0] res1;
  reg [11:0] res2;
  reg        ws_prev;
  reg        pend2;
  reg [1:0]  owner;

  // Writes land at the answer edge; reads are fetched one edge earlier so
  // that the registered read data already stands when waitrequest drops
  wire       wr   = i_avs_write & ~o_avs_waitrequest;
  wire       rd   = i_avs_read & o_avs_waitrequest;
  wire [1:0] mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire       sel2 = ctrl[`CTRL_SEL2];
  wire [3:0] last = ctrl[`CTRL_LEN_HI:`CTRL_LEN_LO];
  wire       ws_rise = i_i2s_ws & ~ws_prev;
  wire [7:0] e1 = pat1[idx];
  wire [7:0] e2 = pat2[idx];

  // Channel legality per converter; supply only on second, peaks on neither
  function ch_ok;
    input       second;
    input [3:0] ch;
    begin
      if (second)
        ch_ok = (ch <= `CH2_MAX) || (ch == `CH_SUPPLY); // [RQ21] [RQ22]
      else
        ch_ok = (ch <= `CH1_MAX);                       // [RQ22]
    end
  endfunction

  // Align a result to the requested resolution, LSBs cleared
  function [11:0] trim;
    input [11:0] d;
    input [1:0]  r;
    begin
      case (r)
        2'h0:    trim = {d[11:3], 3'h0};
        2'h1:    trim = {d[11:2], 2'h0};
        2'h2:    trim = {d[11:1], 1'h0};
        default: trim = d;                              // [RQ1]
      endcase
    end
  endfunction

  // Bus slave: one wait cycle then answer; unmapped reads give zero
  always @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
    end else begin
      if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
      if (rd) begin
        o_avs_readdata <= 32'h0;
        case (i_avs_address)
          `REG_CTRL:       o_avs_readdata <= ctrl;
          `REG_STATUS:     o_avs_readdata <= {26'h0, lp2_done, lp1_done, lp2_busy,
                                              lp1_busy, scan_done, scan_busy};
          `REG_LP1_CTRL:   o_avs_readdata <= {22'h0, lp1_ctrl};
          `REG_LP1_RESULT: o_avs_readdata <= {20'h0, lp1_result}; // [RQ2]
          `REG_LP2_CTRL:   o_avs_readdata <= {22'h0, lp2_ctrl};
          `REG_LP2_RESULT: o_avs_readdata <= {20'h0, lp2_result}; // [RQ2]
          `REG_DMA_WORD:   o_avs_readdata <= {16'h0, o_dma_word};
          default: begin
            if (i_avs_address[7:6] == `PAT1_REGION)
              o_avs_readdata <= {24'h0, pat1[i_avs_address[5:2]]};
            else if (i_avs_address[7:6] == `PAT2_REGION)
              o_avs_readdata <= {24'h0, pat2[i_avs_address[5:2]]};
          end
        endcase
      end
    end
  end

  // Pattern table writes; table keeps its contents, no reset needed
  always @(posedge i_clk) begin
    if (wr && i_avs_address[7:6] == `PAT1_REGION)
      pat1[i_avs_address[5:2]] <= i_avs_writedata[7:0];  // [RQ4] [RQ6]
    if (wr && i_avs_address[7:6] == `PAT2_REGION)
      pat2[i_avs_address[5:2]] <= i_avs_writedata[7:0];  // [RQ4] [RQ6]
  end

  // Control words; start and trigger bits self-clear
  always @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl     <= 32'h0;
      lp1_ctrl <= 10'h0;
      lp2_ctrl <= 10'h0;
    end else begin
      ctrl[`CTRL_START] <= 1'b0;
      ctrl[`CTRL_STOP]  <= 1'b0;
      lp1_ctrl[`LP_TRIG] <= 1'b0;
      lp2_ctrl[`LP_TRIG] <= 1'b0;
      if (wr && i_avs_address == `REG_CTRL)
        ctrl <= {12'h0, i_avs_writedata[19:0]};
      if (wr && i_avs_address == `REG_LP1_CTRL)
        lp1_ctrl <= i_avs_writedata[9:0];
      if (wr && i_avs_address == `REG_LP2_CTRL)
        lp2_ctrl <= i_avs_writedata[9:0];
    end
  end

  // Converter arbitration and scan engine. Low-power shots take the core only
  // while the scan engine is idle, since one core cannot serve both at once.
  always @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      idx <= 4'h0;
      alt_second <= 1'b0;
      scans_left <= 8'h0;
      scan_busy <= 1'b0;
      scan_done <= 1'b0;
      got1 <= 1'b0;
      got2 <= 1'b0;
      res1 <= 12'h0;
      res2 <= 12'h0;
      ws_prev <= 1'b0;
      pend2 <= 1'b0;
      owner <= 2'h0;
      lp1_busy <= 1'b0;
      lp2_busy <= 1'b0;
      lp1_done <= 1'b0;
      lp2_done <= 1'b0;
      lp1_result <= 12'h0;
      lp2_result <= 12'h0;
      o_conv1_start <= 1'b0;
      o_conv1_channel <= 4'h0;
      o_conv1_res <= 2'h0;
      o_conv1_atten <= 2'h0;
      o_conv2_start <= 1'b0;
      o_conv2_channel <= 4'h0;
      o_conv2_res <= 2'h0;
      o_conv2_atten <= 2'h0;
      o_i2s_data <= 1'b0;
      o_dma_word <= 16'h0;
      o_dma_valid <= 1'b0;
      o_scan_irq <= 1'b0;
    end else begin
      ws_prev <= i_i2s_ws;
      o_conv1_start <= 1'b0;
      o_conv2_start <= 1'b0;
      o_i2s_data <= 1'b0;
      o_dma_valid <= 1'b0;
      o_scan_irq <= 1'b0;
      // Status read of done flags clears them; a new event wins the clear
      if (rd && i_avs_address == `REG_STATUS) begin
        scan_done <= 1'b0;
        lp1_done <= 1'b0;
        lp2_done <= 1'b0;
      end
      // Low-power single shots: one conversion per trigger, no sequencing
      // A channel the core cannot reach is refused: no start, no done
      if (lp1_ctrl[`LP_TRIG] && !lp1_busy && !scan_busy &&
          ch_ok(1'b0, lp1_ctrl[`LP_CH_HI:`LP_CH_LO])) begin     // [RQ2] [RQ3] [RQ22]
        lp1_busy <= 1'b1;
        o_conv1_start <= 1'b1;
        o_conv1_channel <= lp1_ctrl[`LP_CH_HI:`LP_CH_LO];
        o_conv1_res <= lp1_ctrl[`LP_RES_HI:`LP_RES_LO];             // [RQ1]
        o_conv1_atten <= 2'h0;
      end
      if (lp2_ctrl[`LP_TRIG] && !lp2_busy && !scan_busy &&
          ch_ok(1'b1, lp2_ctrl[`LP_CH_HI:`LP_CH_LO])) begin     // [RQ2] [RQ3] [RQ22]
        lp2_busy <= 1'b1;
        o_conv2_start <= 1'b1;
        o_conv2_channel <= lp2_ctrl[`LP_CH_HI:`LP_CH_LO];
        o_conv2_res <= lp2_ctrl[`LP_RES_HI:`LP_RES_LO];             // [RQ1]
        o_conv2_atten <= 2'h0;
      end
      if (lp1_busy && i_conv1_done) begin
        lp1_busy <= 1'b0;
        lp1_done <= 1'b1;
        lp1_result <= trim(i_conv1_data, o_conv1_res);              // [RQ2]
      end
      if (lp2_busy && i_conv2_done) begin
        lp2_busy <= 1'b0;
        lp2_done <= 1'b1;
        lp2_result <= trim(i_conv2_data, o_conv2_res);              // [RQ2]
      end
      case (state)
        ST_IDLE: begin
          // Software start only; no path exists to fire one conversion
          if (ctrl[`CTRL_START] && !lp1_busy && !lp2_busy) begin    // [RQ15]
            scan_busy <= 1'b1;
            idx <= 4'h0;
            alt_second <= 1'b0;
            scans_left <= ctrl[`CTRL_SCANS_HI:`CTRL_SCANS_LO];
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // I2S word-select paces each measurement when selected
          if (ctrl[`CTRL_STOP]) begin
            state <= ST_IDLE;
            scan_busy <= 1'b0;
          end else if (!ctrl[`CTRL_WS_TRIG] || ws_rise) begin      // [RQ15] [RQ17]
            got1 <= 1'b0;
            got2 <= 1'b0;
            owner <= 2'h0;
            pend2 <= 1'b0;
            if (mode == `MODE_DOUBLE) begin                         // [RQ9]
              owner <= 2'h3;
              o_conv1_start <= ch_ok(1'b0, e1[`PE_CH_HI:`PE_CH_LO]);
              o_conv2_start <= ch_ok(1'b1, e2[`PE_CH_HI:`PE_CH_LO]);
              got1 <= ~ch_ok(1'b0, e1[`PE_CH_HI:`PE_CH_LO]);
              got2 <= ~ch_ok(1'b1, e2[`PE_CH_HI:`PE_CH_LO]);
            end else if ((mode == `MODE_ALT && alt_second) ||
                         (mode == `MODE_SINGLE && sel2)) begin     // [RQ8] [RQ10]
              owner <= 2'h2;
              o_conv2_start <= ch_ok(1'b1, e2[`PE_CH_HI:`PE_CH_LO]);
              got1 <= 1'b1;
              got2 <= ~ch_ok(1'b1, e2[`PE_CH_HI:`PE_CH_LO]);
            end else begin                                          // [RQ8] [RQ10]
              owner <= 2'h1;
              o_conv1_start <= ch_ok(1'b0, e1[`PE_CH_HI:`PE_CH_LO]);
              got1 <= ~ch_ok(1'b0, e1[`PE_CH_HI:`PE_CH_LO]);
              got2 <= 1'b1;
            end
            // Entry fields steer the cores          [RQ7]
            o_conv1_channel <= e1[`PE_CH_HI:`PE_CH_LO];
            o_conv1_res <= e1[`PE_RES_HI:`PE_RES_LO];                // [RQ1]
            o_conv1_atten <= e1[`PE_ATT_HI:`PE_ATT_LO];
            o_conv2_channel <= e2[`PE_CH_HI:`PE_CH_LO];
            o_conv2_res <= e2[`PE_RES_HI:`PE_RES_LO];                // [RQ1]
            o_conv2_atten <= e2[`PE_ATT_HI:`PE_ATT_LO];
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (i_conv1_done && owner[0]) begin
            got1 <= 1'b1;
            res1 <= trim(i_conv1_data, o_conv1_res);
          end
          if (i_conv2_done && owner[1]) begin
            got2 <= 1'b1;
            res2 <= trim(i_conv2_data, o_conv2_res);
          end
          if ((got1 || (i_conv1_done && owner[0])) &&
              (got2 || (i_conv2_done && owner[1])))
            state <= ST_PACK;
        end
        default: begin
          // Pack one word per converter; double mode sends second word next
          if (mode == `MODE_SINGLE) begin
            o_dma_word <= sel2 ? {o_conv2_channel, res2} :
                                 {o_conv1_channel, res1};           // [RQ11] [RQ14]
          end else if (owner[0] && !pend2) begin
            o_dma_word <= {1'b0, o_conv1_channel, res1[11:1]};      // [RQ12] [RQ13]
          end else begin
            o_dma_word <= {1'b1, o_conv2_channel, res2[11:1]};      // [RQ12] [RQ13] [RQ14]
          end
          // DMA and I2S delivery from every mode and either table, gated only by the enable bits
          o_dma_valid <= ctrl[`CTRL_DMA_EN];                        // [RQ20]
          o_i2s_data <= ctrl[`CTRL_I2S_ROUTE];                      // [RQ18] [RQ19]
          if (owner == 2'h3 && !pend2) begin
            pend2 <= 1'b1;
          end else begin
            pend2 <= 1'b0;
            alt_second <= (mode == `MODE_ALT) ? ~alt_second : 1'b0;
            if (mode != `MODE_ALT || alt_second) begin
              idx <= (idx == last) ? 4'h0 : idx + 4'h1;             // [RQ5]
            end
            state <= ST_WAIT;
            if ((mode != `MODE_ALT || alt_second) && idx == last) begin
              if (scans_left == 8'h0) begin
                state <= ST_IDLE;
                scan_busy <= 1'b0;
                scan_done <= 1'b1;
                o_scan_irq <= ctrl[`CTRL_DMA_EN];                   // [RQ16]
              end else begin
                scans_left <= scans_left - 8'h1;
              end
            end
          end
        end
      endcase
    end
  end
endmodule

// file: dv/scan_ctrl_props.sv
// Purpose: Port checker for the scan controller
// Assumes: Control byte shadowed from accepted bus writes
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`include "scan_defines.vh"
module scan_ctrl_props (
  input wire        i_clk,
  input wire        i_resetn,
  input wire [7:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire        o_avs_waitrequest,
  input wire        o_conv1_start,
  input wire [3:0]  o_conv1_channel,
  input wire        i_conv1_done,
  input wire        o_conv2_start,
  input wire [3:0]  o_conv2_channel,
  input wire        o_i2s_data,
  input wire        o_dma_valid,
  input wire        o_scan_irq
);
  reg  [7:0] ctrl;
  wire [1:0] mode;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Shadow copy; the start bit self-clears in the design but not here
  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      ctrl <= 8'h00;
    else if (i_avs_write && !o_avs_waitrequest && i_avs_address == `REG_CTRL)
      ctrl <= i_avs_writedata[7:0];
  assign mode = ctrl[3:2];
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing");
  dma_gate_a: assert property (o_dma_valid |-> ctrl[7])
    else $error("dma word while dma off");
  irq_gate_a: assert property (o_scan_irq |-> ctrl[7])
    else $error("irq while dma off");
  i2s_gate_a: assert property (o_i2s_data |-> ctrl[5])
    else $error("i2s ready while not routed");
  double_pair_a: assert property (mode == `MODE_DOUBLE && o_conv1_start &&
    o_conv2_channel <= `CH2_MAX |-> o_conv2_start) else $error("double mode not parallel");
  alt_split_a: assert property (mode == `MODE_ALT && o_conv1_start |-> !o_conv2_start)
    else $error("alternate mode overlaps");
  conv1_range_a: assert property (o_conv1_start |-> o_conv1_channel <= `CH1_MAX)
    else $error("bad first channel");
  conv2_range_a: assert property (o_conv2_start |->
    (o_conv2_channel <= `CH2_MAX || o_conv2_channel == `CH_SUPPLY)) else $error("bad second channel");
  single_word_a: assert property (o_dma_valid && mode == `MODE_SINGLE && !ctrl[4]
    && o_conv1_channel <= `CH1_MAX |-> $past(i_conv1_done, 2))
    else $error("single word not after done");
  cover property (o_dma_valid && mode == `MODE_DOUBLE);
  cover property (o_dma_valid && mode == `MODE_ALT);
  cover property (o_scan_irq);
  cover property (o_i2s_data && ctrl[6]);
endmodule
bind sar_adc_scan_controller scan_ctrl_props i_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_conv1_start(o_conv1_start), .o_conv1_channel(o_conv1_channel),
  .i_conv1_done(i_conv1_done), .o_conv2_start(o_conv2_start),
  .o_conv2_channel(o_conv2_channel), .o_i2s_data(o_i2s_data),
  .o_dma_valid(o_dma_valid), .o_scan_irq(o_scan_irq));

// file: dv/conv_core_model.sv
// Purpose: Behavioural converter core, start in, done and result out
// Assumes: A new start restarts the count
// Notes:   Data toggles outside the done cycle so stale values never match
`timescale 1ns/1ps
module conv_core_model #(
  parameter int          LAT  = 2,
  parameter logic [11:0] SALT = 12'h3a5
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic [3:0] i_channel,
  output logic            o_done,
  output logic [11:0]     o_data
);
  int         cnt;
  logic [3:0] ch;
  // Result depends on the channel so a wrong table entry shows in the word
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
      ch <= 4'h0;
      o_done <= 1'b0;
      o_data <= ~SALT;
    end else begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_start) begin
        cnt <= LAT;
        ch <= i_channel;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_done <= 1'b1;
        o_data <= {ch, 8'h00} ^ SALT; // Full 12-bit result
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// file: dv/test_sar_adc_scan_controller.sv
// Purpose: Self-checking bench for the scan controller
// Assumes: Prompt first core, slow second core
// Notes:   Row table for scan modes, hand tests for the rest
`timescale 1ns/1ps
`include "scan_defines.vh"
module test_sar_adc_scan_controller;
  localparam logic [11:0] S1 = 12'h3a5;
  localparam logic [11:0] S2 = 12'h5c3;
  localparam logic [31:0] ROW_C [4] = '{32'h3a1, 32'h2b1, 32'h1a5, 32'h2a9};
  localparam int          ROW_N [4] = '{4, 3, 4, 6};
  logic        clk, resetn, rd, wr, ws, wreq, st1, st2, dn1, dn2, i2s, dv, irq, scanning;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  ch1, ch2, lch;
  logic [1:0]  res1, res2, lres, att1, att2;
  logic [11:0] d1, d2;
  logic [15:0] dword;
  logic [15:0] words[$];
  int          failures, checks_done, i2s_cnt, irq_cnt, st1_cnt, j;
  sar_adc_scan_controller i_dut (.i_clk(clk), .i_resetn(resetn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_conv1_start(st1), .o_conv1_channel(ch1), .o_conv1_res(res1),
    .o_conv1_atten(att1), .i_conv1_done(dn1), .i_conv1_data(d1), .o_conv2_start(st2),
    .o_conv2_channel(ch2), .o_conv2_res(res2), .o_conv2_atten(att2), .i_conv2_done(dn2),
    .i_conv2_data(d2), .i_i2s_ws(ws), .o_i2s_data(i2s), .o_dma_word(dword),
    .o_dma_valid(dv), .o_scan_irq(irq));
  conv_core_model #(.LAT(2), .SALT(S1)) i_core1 (.i_clk(clk), .i_resetn(resetn),
    .i_start(st1), .i_channel(ch1), .o_done(dn1), .o_data(d1));
  conv_core_model #(.LAT(7), .SALT(S2)) i_core2 (.i_clk(clk), .i_resetn(resetn),
    .i_start(st2), .i_channel(ch2), .o_done(dn2), .o_data(d2));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Output monitor; pulses last one cycle so every edge is looked at
  always @(posedge clk) begin
    if (dv) words.push_back(dword);
    i2s_cnt += int'(i2s);
    irq_cnt += int'(irq);
    st1_cnt += int'(st1);
    if (st2) begin
      lres <= res2;
      lch <= ch2;
    end
    // Table rows tie attenuation to the channel, all at full resolution
    if (st1 && scanning) chk("conv1 fields", {2'b11, ch1[1:0]}, {res1, att1});
    if (st2 && scanning) chk("conv2 fields", {2'b11, ~ch2[1:0]}, {res2, att2});
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; the extra edge keeps release and next raise apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0);
    got = rdata;
    chk("bus wait", 2, n);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] exp_word(input logic [1:0] m, input logic s, input int k);
    logic [2:0]  i;
    logic [3:0]  c1, c2;
    logic [11:0] e1, e2;
    i = (m == `MODE_SINGLE) ? k[2:0] : k[3:1];
    c1 = {1'b0, i};
    c2 = {1'b0, ~i};
    e1 = {c1, 8'h00} ^ S1;
    e2 = {c2, 8'h00} ^ S2;
    if (m == `MODE_SINGLE) return s ? {c2, e2} : {c1, e1};
    return k[0] ? {1'b1, c2, e2[11:1]} : {1'b0, c1, e1[11:1]};
  endfunction
  // Start a scan, collect words, then give stragglers time to show
  task automatic scan(input logic [31:0] c, input int n, input int ni);
    int k;
    words.delete();
    i2s_cnt = 0;
    irq_cnt = 0;
    scanning = 1'b1;
    bus(1'b1, `REG_CTRL, c);
    k = 0;
    while ((words.size() < n || n == 0) && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (20) @(posedge clk);
    scanning = 1'b0;
    chk("word count", n, words.size());
    for (k = 0; k < n && k < words.size(); k++)
      chk("dma word", exp_word(c[3:2], c[4], k), words[k]);
    chk("irq count", c[7], irq_cnt);
    chk("i2s count", ni, i2s_cnt);
    $display("scan %h done", c);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    end_sim;
  end
  initial begin
    resetn = 1'b0;
    {rd, wr, ws, scanning, addr, wdata} = '0;
    {failures, checks_done, i2s_cnt, irq_cnt, st1_cnt} = '0;
    @(posedge clk);
    #1;
    chk("reset wait", 1, wreq);
    chk("reset pulses", 0, {dv, st1, st2, irq});
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // Table entries: channel 7:4, resolution 12 bit, attenuation 1:0
    for (j = 0; j < 16; j++) begin
      bus(1'b1, `REG_PAT1_BASE + 8'(4 * j), {24'h0, 1'b0, j[2:0], 2'b11, j[1:0]});
      bus(1'b1, `REG_PAT2_BASE + 8'(4 * j), {24'h0, 1'b0, ~j[2:0], 2'b11, j[1:0]});
    end
    bus(1'b0, `REG_PAT1_BASE + 8'h14, 0);
    chk("entry readback", 32'h5d, got);
    bus(1'b0, 8'h3c, 0);
    chk("unmapped read", 0, got);
    $display("registers done");
    words.delete();
    for (j = 0; j < 4; j++) begin
      bus(1'b1, `REG_LP2_CTRL, {22'h0, j[1:0], 4'h9, 4'h1});
      repeat (20) @(posedge clk);
      bus(1'b0, `REG_LP2_RESULT, 0);
      chk("lp res code", j, lres);
      chk("lp channel", 9, lch);
      chk("lp result", ({4'h9, 8'h00} ^ S2) & (12'hfff << (3 - j)), got);
    end
    chk("lp dma words", 0, words.size());
    $display("single shots done");
    for (j = 0; j < 4; j++)
      scan(ROW_C[j], ROW_N[j], ROW_N[j]);
    scan(32'h1f81, 32, 0);
    scan(32'h121, 0, 2);
    words.delete();
    j = st1_cnt;
    bus(1'b1, `REG_CTRL, 32'he1);
    repeat (30) @(posedge clk);
    chk("ws hold", j, st1_cnt);
    ws <= 1'b1;
    repeat (40) @(posedge clk);
    chk("ws words", 1, words.size());
    if (words.size() > 0) chk("ws word", exp_word(2'h0, 1'b0, 0), words[0]);
    ws <= 1'b0;
    // Second single shot and last scan left their done flags; a read clears them
    bus(1'b0, `REG_STATUS, 0);
    chk("status flags", 32'h22, got);
    bus(1'b0, `REG_STATUS, 0);
    chk("status clear", 0, got);
    $display("word select pacing done");
    end_sim;
  end
endmodule
